// ---- hw/ssfg_defs.svh ----
`ifndef SSFG_DEFS_SVH
`define SSFG_DEFS_SVH

// feature-query leaf numbers and the bits they report
`define SSFG_LEAF_BASIC 32'h0000_0001
`define SSFG_LEAF_DETAIL 32'h0000_000d
`define SSFG_SUB_USER 32'h0000_0000
`define SSFG_SUB_EXT 32'h0000_0001
`define SSFG_SUPPORT_BIT 26
`define SSFG_OS_ECHO_BIT 27

// control_reg_four position of the os save enable bit
`define SSFG_OS_SAVE_BIT 18

// extended_feature_mask component positions
`define SSFG_X87_BIT 0
`define SSFG_SCALAR_BIT 1
`define SSFG_WIDE_BIT 2
`define SSFG_BND_HI 4
`define SSFG_BND_LO 3
`define SSFG_MASK_RESET 64'h0000_0000_0000_0001
`define SSFG_MASK_RSVD 64'hffff_ffff_ffff_fd00
`define SSFG_PAIR_SET 2'h3
`define SSFG_PAIR_CLR 2'h0
`define SSFG_WIDE_ALONE 2'h2

// mask read/write selectors
`define SSFG_SEL_MASK 32'h0000_0000
`define SSFG_SEL_INIT 32'h0000_0001

// save area geometry
`define SSFG_LEGACY_BYTES 32'h0000_0240
`define SSFG_ALIGN_MASK 32'h0000_003f
`define SSFG_NCOMP 5
`define SSFG_DEF_SIZE {32'h40, 32'h40, 32'h100, 32'h0, 32'h0}
`define SSFG_DEF_OFFS {32'h400, 32'h3c0, 32'h240, 32'h0, 32'h0}
`define SSFG_DEF_ALIGN 5'h00
`define SSFG_DEF_USER_MAP 64'h0000_0000_0000_001f
`define SSFG_DEF_SUPV_MAP 64'h0000_0000_0000_0000

`endif

// ---- hw/ssfg_enum_rom.sv ----
`include "ssfg_defs.svh"

module ssfg_enum_rom #(
  parameter logic SUPPORT = 1'b1,
  parameter logic [63:0] USER_MAP = `SSFG_DEF_USER_MAP,
  parameter logic [63:0] SUPV_MAP = `SSFG_DEF_SUPV_MAP,
  parameter logic HAS_OPT = 1'b1,
  parameter logic HAS_CMP = 1'b1,
  parameter logic HAS_SEL1 = 1'b1,
  parameter logic HAS_SUPV = 1'b0,
  parameter logic [`SSFG_NCOMP*32-1:0] COMP_SIZE = `SSFG_DEF_SIZE,
  parameter logic [`SSFG_NCOMP*32-1:0] COMP_OFFS = `SSFG_DEF_OFFS,
  parameter logic [`SSFG_NCOMP-1:0] COMP_ALIGN = `SSFG_DEF_ALIGN
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  ssfg_query_if.table_side q
);

  localparam int N = `SSFG_NCOMP;
  // every component the table knows, user or supervisor
  localparam logic [63:0] ANY_MAP = USER_MAP | SUPV_MAP;

  // running area ends: standard format over map and over mask, compacted over union
  logic [31:0] end_all [N+1];
  logic [31:0] end_cur [N+1];
  logic [31:0] end_cmp [N+1];
  logic [63:0] union_mask;

  assign union_mask = q.user_mask | q.supv_mask;
  assign end_all[0] = `SSFG_LEGACY_BYTES;
  assign end_cur[0] = `SSFG_LEGACY_BYTES;
  assign end_cmp[0] = `SSFG_LEGACY_BYTES;

  // one stage per component: max of section ends, compacted running sum
  for (genvar i = 0; i < N; i++)
  begin : g_comp
    wire [31:0] top_w = COMP_OFFS[i*32 +: 32] + COMP_SIZE[i*32 +: 32];
    wire [31:0] rnd_w = (end_cmp[i] + `SSFG_ALIGN_MASK) & ~`SSFG_ALIGN_MASK;
    wire [31:0] base_w = COMP_ALIGN[i] ? rnd_w : end_cmp[i];
    assign end_all[i+1] = (USER_MAP[i] && top_w > end_all[i]) ? top_w : end_all[i];
    assign end_cur[i+1] = (USER_MAP[i] && q.user_mask[i] && top_w > end_cur[i]) ?
                          top_w : end_cur[i];
    // components 0 and 1 live in the legacy region and add nothing
    assign end_cmp[i+1] = (ANY_MAP[i] && union_mask[i] && i > 1) ?
                          base_w + COMP_SIZE[i*32 +: 32] : end_cmp[i];
  end

  // per-component detail lookup
  wire is_basic = q.leaf == `SSFG_LEAF_BASIC;
  wire is_detail = (q.leaf == `SSFG_LEAF_DETAIL) && SUPPORT;
  wire in_table = q.sub < 32'(N);
  wire [2:0] idx = q.sub[2:0];
  wire comp_ok = in_table && (q.sub > `SSFG_SUB_EXT) && ANY_MAP[idx];
  wire comp_supv = SUPV_MAP[idx];

  ssfg_pkg::ssfg_result_t res_d;

  // answer selection; unknown leaves and components read all zero
  always_comb
  begin
    res_d = '0;
    if (is_basic)
    begin
      res_d.ecx[`SSFG_SUPPORT_BIT] = SUPPORT;
      res_d.ecx[`SSFG_OS_ECHO_BIT] = q.os_en;
    end
    else if (is_detail && q.sub == `SSFG_SUB_USER)
    begin
      res_d.eax = USER_MAP[31:0];
      res_d.edx = USER_MAP[63:32];
      res_d.ecx = end_all[N];
      res_d.ebx = end_cur[N];
    end
    else if (is_detail && q.sub == `SSFG_SUB_EXT)
    begin
      res_d.eax = {28'h0000000, HAS_SUPV, HAS_SEL1, HAS_CMP, HAS_OPT};
      res_d.ebx = end_cmp[N];
      res_d.ecx = SUPV_MAP[31:0];
      res_d.edx = SUPV_MAP[63:32];
    end
    else if (is_detail && comp_ok)
    begin
      res_d.eax = COMP_SIZE[idx*32 +: 32];
      res_d.ebx = comp_supv ? 32'h0 : COMP_OFFS[idx*32 +: 32];
      res_d.ecx = {30'h0, COMP_ALIGN[idx], comp_supv};
    end
  end

  // answer register: one cycle after the request
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      q.ack <= 1'b0;
      q.res <= '0;
    end
    else
    begin
      q.ack <= q.req;
      if (q.req)
        q.res <= res_d;
    end
  end

endmodule : ssfg_enum_rom

// ---- hw/ssfg_gate.sv ----
`include "ssfg_defs.svh"

// Function
// RULE_01 - support bit clear rejects everything, no detail
// RULE_02 - support bit set enables core instructions, detail
// RULE_03 - os save enable settable only when supported
// RULE_04 - sub-function 0 user map, bits 0,1 set
// RULE_05 - sub-function 0 reports full and current sizes
// RULE_06 - optimized save faults when not reported
// RULE_07 - compacted save faults when not reported
// RULE_08 - report selector 1 mask read support
// RULE_09 - supervisor ops fault unless reported; implies compaction
// RULE_10 - sub-function 1 union size, supervisor map
// RULE_11 - per-component size, offset, supervisor flag
// RULE_12 - per-component alignment bit, rest zero
// RULE_13 - unsupported component returns all zero
// RULE_14 - os save enable clear: invalid opcode
// RULE_15 - mask write loads 64 bits at privilege 0
// RULE_16 - mask bit 0 always one
// RULE_17 - mask bit 1 writable, never gates execution
// RULE_18 - wide vector needs enable and mask bit 2
// RULE_19 - wide without scalar state is refused
// RULE_20 - clearing bit 2 keeps wide state
// RULE_21 - bounds ops are no-ops unless enabled
// RULE_22 - bounds pair all or nothing
// RULE_23 - reserved mask bits refused, reset zero
// RULE_24 - faulting write keeps mask; unsupported bits refused
module ssfg_gate #(
  parameter logic SUPPORT = 1'b1,
  parameter logic [63:0] USER_MAP = `SSFG_DEF_USER_MAP,
  parameter logic [63:0] SUPV_MAP = `SSFG_DEF_SUPV_MAP,
  parameter logic HAS_OPT = 1'b1,
  parameter logic HAS_CMP = 1'b1,
  parameter logic HAS_SEL1 = 1'b1,
  parameter logic HAS_SUPV = 1'b0,
  parameter logic [`SSFG_NCOMP*32-1:0] COMP_SIZE = `SSFG_DEF_SIZE,
  parameter logic [`SSFG_NCOMP*32-1:0] COMP_OFFS = `SSFG_DEF_OFFS,
  parameter logic [`SSFG_NCOMP-1:0] COMP_ALIGN = `SSFG_DEF_ALIGN
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // control_reg_four write
  input wire logic cr4_wr_i,
  input wire logic [31:0] cr4_wdata_i,
  output logic os_save_enable_o,
  // instruction gate request
  input wire logic instr_valid_i,
  input wire ssfg_pkg::ssfg_op_t instr_op_i,
  input wire logic [1:0] privilege_level_i,
  input wire logic [31:0] instr_sel_i,
  input wire logic [63:0] instr_wdata_i,
  input wire logic [63:0] init_state_i,
  input wire logic [63:0] supv_mask_i,
  // instruction gate answer
  output logic done_o,
  output logic exec_ok_o,
  output logic invalid_opcode_fault_o,
  output logic protection_fault_o,
  output logic bounds_nop_o,
  output logic bounds_prefix_ignore_o,
  output logic [63:0] rd_data_o,
  output logic [63:0] extended_feature_mask_o,
  // feature query
  input wire logic query_valid_i,
  input wire logic [31:0] query_leaf_i,
  input wire logic [31:0] query_sub_i,
  output logic query_done_o,
  output logic [31:0] query_eax_o,
  output logic [31:0] query_ebx_o,
  output logic [31:0] query_ecx_o,
  output logic [31:0] query_edx_o
);

  // refuse configurations the table and gate cannot serve
  if (USER_MAP[`SSFG_SCALAR_BIT:`SSFG_X87_BIT] != 2'h3)
  begin : g_bad_map
    $error("user map must hold components 0 and 1");
  end
  if (HAS_SUPV && !HAS_CMP)
  begin : g_bad_supv
    $error("supervisor support requires compaction support");
  end
  if (((USER_MAP | SUPV_MAP) >> `SSFG_NCOMP) != 64'h0)
  begin : g_bad_range
    $error("maps name components beyond the size table");
  end
  if ((USER_MAP & SUPV_MAP) != 64'h0)
  begin : g_bad_overlap
    $error("a component cannot be both user and supervisor");
  end

  // architectural state
  logic os_en_q;
  logic os_en_d;
  logic [63:0] mask_q;
  logic [63:0] mask_d;

  // registered answer of the gate
  logic done_q;
  logic ok_q;
  logic ud_q;
  logic gp_q;
  logic bnop_q;
  logic bpfx_q;
  logic [63:0] rd_q;

  // RULE_03 os enable gated
  // the bit only sticks when the feature set exists, otherwise it reads 0
  assign os_en_d = cr4_wr_i ? (cr4_wdata_i[`SSFG_OS_SAVE_BIT] & SUPPORT) : os_en_q;

  // op class decode
  wire op_save = instr_op_i == ssfg_pkg::SSFG_OP_SAVE;
  wire op_rest = instr_op_i == ssfg_pkg::SSFG_OP_RESTORE;
  wire op_rcmp = instr_op_i == ssfg_pkg::SSFG_OP_RESTORE_CMP;
  wire op_opt = instr_op_i == ssfg_pkg::SSFG_OP_OPT_SAVE;
  wire op_csav = instr_op_i == ssfg_pkg::SSFG_OP_CMP_SAVE;
  wire op_ssav = instr_op_i == ssfg_pkg::SSFG_OP_SUPV_SAVE;
  wire op_srst = instr_op_i == ssfg_pkg::SSFG_OP_SUPV_RESTORE;
  wire op_mrd = instr_op_i == ssfg_pkg::SSFG_OP_MASK_READ;
  wire op_mwr = instr_op_i == ssfg_pkg::SSFG_OP_MASK_WRITE;
  wire op_wide = instr_op_i == ssfg_pkg::SSFG_OP_WIDE_VEC;
  wire op_bnd = instr_op_i == ssfg_pkg::SSFG_OP_BOUNDS;
  wire op_br = instr_op_i == ssfg_pkg::SSFG_OP_BRANCH;
  wire op_model = (instr_op_i == ssfg_pkg::SSFG_OP_MODEL_RD) ||
                  (instr_op_i == ssfg_pkg::SSFG_OP_MODEL_WR);

  // every instruction of the feature set itself
  wire op_family = op_save | op_rest | op_rcmp | op_opt | op_csav |
                   op_ssav | op_srst | op_mrd | op_mwr;
  wire priv_zero = privilege_level_i == 2'h0;
  wire sel_mask = instr_sel_i == `SSFG_SEL_MASK;
  wire sel_init = instr_sel_i == `SSFG_SEL_INIT;

  // RULE_01 no support faults
  // RULE_14 enable clear faults
  // with the set unsupported the enable cannot be 1, so both fold into one term
  wire ud_family = op_family & (!SUPPORT | !os_en_q);

  // RULE_06 optimized save gated
  wire ud_opt = op_opt & !HAS_OPT;
  // RULE_07 compacted forms gated
  wire ud_cmp = (op_csav | op_rcmp) & !HAS_CMP;
  // RULE_09 supervisor ops gated
  wire ud_supv = (op_ssav | op_srst) & !HAS_SUPV;
  // RULE_18 wide vector enable
  wire wide_on = os_en_q & mask_q[`SSFG_WIDE_BIT];
  wire ud_wide = op_wide & !wide_on;

  wire ud_any = ud_family | ud_opt | ud_cmp | ud_supv | ud_wide;

  // value checks for a selector-0 mask write
  wire [63:0] wv = instr_wdata_i;
  wire [1:0] wv_bnd = wv[`SSFG_BND_HI:`SSFG_BND_LO];
  // RULE_16 bit 0 must be one
  wire bad_x87 = !wv[`SSFG_X87_BIT];
  // RULE_19 wide without scalar
  wire bad_wide = wv[`SSFG_WIDE_BIT:`SSFG_SCALAR_BIT] == `SSFG_WIDE_ALONE;
  // RULE_22 bounds pair all or nothing
  wire bad_bnd = (wv_bnd != `SSFG_PAIR_CLR) && (wv_bnd != `SSFG_PAIR_SET);
  // RULE_23 reserved bits
  wire bad_rsvd = (wv & `SSFG_MASK_RSVD) != 64'h0;
  // RULE_04 map limits the mask
  // RULE_24 unsupported bits refused
  // this also covers bit 2 and bits 4:3 when the map lacks them
  wire bad_map = (wv & ~USER_MAP) != 64'h0;
  wire bad_value = bad_x87 | bad_wide | bad_bnd | bad_rsvd | bad_map;

  // RULE_15 privilege and selector
  // other selectors are not writable here, so they take a protection fault
  wire gp_mwr = op_mwr & (!priv_zero | !sel_mask | bad_value);
  // RULE_08 selector 1 read
  wire gp_mrd = op_mrd & !sel_mask & !(sel_init & HAS_SEL1);
  // RULE_09 supervisor mask access
  wire gp_model = op_model & (!HAS_SUPV | !priv_zero | !os_en_q);

  // an invalid opcode outranks a protection fault
  wire gp_any = !ud_any & (gp_mwr | gp_mrd | gp_model);

  // RULE_21 bounds enable
  // the pair only counts as on when both bits and the enable agree
  wire bnd_on = os_en_q && (mask_q[`SSFG_BND_HI:`SSFG_BND_LO] == `SSFG_PAIR_SET);
  wire bnop_d = op_bnd & !bnd_on;
  wire bpfx_d = op_br & !bnd_on;

  // RULE_24 faulting write discarded
  wire mask_commit = instr_valid_i & op_mwr & !ud_any & !gp_any;

  // RULE_15 full 64-bit load
  // RULE_20 clearing bit 2 touches only the mask
  // the wide register file is outside this block; nothing here clears it
  // RULE_16 bit 0 held at one
  assign mask_d = mask_commit ? (wv | `SSFG_MASK_RESET) : mask_q;

  // RULE_08 init optimization report
  // selector 1 shows enabled components that are not in their initial state
  wire [63:0] rd_d = sel_init ? (mask_q & init_state_i) : mask_q;

  // RULE_17 scalar vector never gated
  // scalar-vector and other ops fall through with no fault term at all
  wire ok_d = !ud_any & !gp_any & !bnop_d;

  // architectural state registers
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      os_en_q <= 1'b0;
      // RULE_23 reserved bits reset zero
      mask_q <= `SSFG_MASK_RESET;
    end
    else
    begin
      os_en_q <= os_en_d;
      mask_q <= mask_d;
    end
  end

  // gate answer registers, one cycle after the request
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      done_q <= 1'b0;
      ok_q <= 1'b0;
      ud_q <= 1'b0;
      gp_q <= 1'b0;
      bnop_q <= 1'b0;
      bpfx_q <= 1'b0;
    end
    else
    begin
      done_q <= instr_valid_i;
      ok_q <= instr_valid_i & ok_d;
      ud_q <= instr_valid_i & ud_any;
      gp_q <= instr_valid_i & gp_any;
      bnop_q <= instr_valid_i & bnop_d;
      bpfx_q <= instr_valid_i & bpfx_d;
    end
  end

  // read data only moves on a successful mask read, so it holds otherwise
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      rd_q <= 64'h0;
    else if (instr_valid_i && op_mrd && !ud_any && !gp_any)
      rd_q <= rd_d;
  end

  // feature query table
  ssfg_query_if qif ();

  // RULE_02 detail when supported
  // RULE_05 sizes follow the live mask
  assign qif.req = query_valid_i;
  assign qif.leaf = query_leaf_i;
  assign qif.sub = query_sub_i;
  assign qif.os_en = os_en_q;
  assign qif.user_mask = mask_q;
  assign qif.supv_mask = supv_mask_i;

  // RULE_10 union size, supervisor map
  // RULE_11 per-component details
  // RULE_12 alignment bit
  // RULE_13 unknown reads zero
  ssfg_enum_rom #(
    .SUPPORT(SUPPORT),
    .USER_MAP(USER_MAP),
    .SUPV_MAP(SUPV_MAP),
    .HAS_OPT(HAS_OPT),
    .HAS_CMP(HAS_CMP),
    .HAS_SEL1(HAS_SEL1),
    .HAS_SUPV(HAS_SUPV),
    .COMP_SIZE(COMP_SIZE),
    .COMP_OFFS(COMP_OFFS),
    .COMP_ALIGN(COMP_ALIGN)
  ) u_rom (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .q(qif.table_side)
  );

  // outputs, all from flip-flops
  assign os_save_enable_o = os_en_q;
  assign done_o = done_q;
  assign exec_ok_o = ok_q;
  assign invalid_opcode_fault_o = ud_q;
  assign protection_fault_o = gp_q;
  assign bounds_nop_o = bnop_q;
  assign bounds_prefix_ignore_o = bpfx_q;
  assign rd_data_o = rd_q;
  assign extended_feature_mask_o = mask_q;
  assign query_done_o = qif.ack;
  assign query_eax_o = qif.res.eax;
  assign query_ebx_o = qif.res.ebx;
  assign query_ecx_o = qif.res.ecx;
  assign query_edx_o = qif.res.edx;

endmodule : ssfg_gate

// ---- hw/ssfg_pkg.sv ----
package ssfg_pkg;

  // instruction classes presented to the gate
  typedef enum logic [3:0] {
    SSFG_OP_SAVE = 4'h0,
    SSFG_OP_RESTORE = 4'h1,
    SSFG_OP_RESTORE_CMP = 4'h2,
    SSFG_OP_OPT_SAVE = 4'h3,
    SSFG_OP_CMP_SAVE = 4'h4,
    SSFG_OP_SUPV_SAVE = 4'h5,
    SSFG_OP_SUPV_RESTORE = 4'h6,
    SSFG_OP_MASK_READ = 4'h7,
    SSFG_OP_MASK_WRITE = 4'h8,
    SSFG_OP_WIDE_VEC = 4'h9,
    SSFG_OP_BOUNDS = 4'ha,
    SSFG_OP_BRANCH = 4'hb,
    SSFG_OP_SCALAR_VEC = 4'hc,
    SSFG_OP_MODEL_RD = 4'hd,
    SSFG_OP_MODEL_WR = 4'he,
    SSFG_OP_OTHER = 4'hf
  } ssfg_op_t;

  // one query result, four words
  typedef struct packed {
    logic [31:0] eax;
    logic [31:0] ebx;
    logic [31:0] ecx;
    logic [31:0] edx;
  } ssfg_result_t;

endpackage : ssfg_pkg

// ---- hw/ssfg_query_if.sv ----
interface ssfg_query_if;
  // request side
  logic req;
  logic [31:0] leaf;
  logic [31:0] sub;
  logic os_en;
  logic [63:0] user_mask;
  logic [63:0] supv_mask;
  // answer side, registered in the table module
  logic ack;
  ssfg_pkg::ssfg_result_t res;

  modport host (
    output req,
    output leaf,
    output sub,
    output os_en,
    output user_mask,
    output supv_mask,
    input ack,
    input res
  );

  modport table_side (
    input req,
    input leaf,
    input sub,
    input os_en,
    input user_mask,
    input supv_mask,
    output ack,
    output res
  );
endinterface : ssfg_query_if

// ---- tb/ssfg_gate_sva.sv ----
// watches the gate ports; assertions are only legal while out of reset
module ssfg_gate_sva #(
  parameter logic SUPPORT = 1'h1
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic cr4_wr_i,
  input wire logic [31:0] cr4_wdata_i,
  input wire logic os_save_enable_o,
  input wire logic instr_valid_i,
  input wire ssfg_pkg::ssfg_op_t instr_op_i,
  input wire logic [1:0] privilege_level_i,
  input wire logic exec_ok_o,
  input wire logic invalid_opcode_fault_o,
  input wire logic protection_fault_o,
  input wire logic bounds_nop_o,
  input wire logic [63:0] extended_feature_mask_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  // family instruction and mask write decodes
  wire logic fam_w = instr_valid_i && (instr_op_i <= ssfg_pkg::SSFG_OP_MASK_WRITE);
  wire logic wr_w = instr_valid_i && (instr_op_i == ssfg_pkg::SSFG_OP_MASK_WRITE);
  wire logic [63:0] m_w = extended_feature_mask_o;

  mask_bit0_a: assert property (m_w[0])
    else $error("mask bit 0 cleared");
  wide_pair_a: assert property (m_w[2:1] != 2'h2)
    else $error("wide state enabled without scalar state");
  bounds_pair_a: assert property (m_w[4:3] == 2'h0 || m_w[4:3] == 2'h3)
    else $error("bounds pair split");
  rsvd_zero_a: assert property ((m_w & 64'hffff_ffff_ffff_fd00) == 64'h0)
    else $error("reserved mask bit set");
  os_off_ud_a: assert property (fam_w && !os_save_enable_o
    |=> invalid_opcode_fault_o && !protection_fault_o)
    else $error("family op ran without os enable");
  priv_gp_a: assert property (wr_w && os_save_enable_o && privilege_level_i != 2'h0
    |=> protection_fault_o && !exec_ok_o && $stable(m_w))
    else $error("unprivileged mask write accepted");
  fault_keep_a: assert property (protection_fault_o |-> $stable(m_w))
    else $error("mask changed on a faulting write");
  os_write_a: assert property (cr4_wr_i
    |=> os_save_enable_o == ($past(cr4_wdata_i[18]) & SUPPORT))
    else $error("os enable not loaded from bit 18");
  wide_ud_a: assert property (instr_valid_i
    && instr_op_i == ssfg_pkg::SSFG_OP_WIDE_VEC
    && !(os_save_enable_o && m_w[2]) |=> invalid_opcode_fault_o)
    else $error("wide op ran while not enabled");
  bounds_nop_a: assert property (instr_valid_i
    && instr_op_i == ssfg_pkg::SSFG_OP_BOUNDS
    |=> bounds_nop_o != ($past(os_save_enable_o) && $past(m_w[4:3]) == 2'h3))
    else $error("bounds op nop flag wrong");
  scalar_ok_a: assert property (instr_valid_i
    && instr_op_i == ssfg_pkg::SSFG_OP_SCALAR_VEC |=> exec_ok_o)
    else $error("scalar op was gated");
endmodule : ssfg_gate_sva

bind ssfg_gate ssfg_gate_sva #(.SUPPORT(SUPPORT)) u_sva (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cr4_wr_i(cr4_wr_i), .cr4_wdata_i(cr4_wdata_i),
  .os_save_enable_o(os_save_enable_o), .instr_valid_i(instr_valid_i),
  .instr_op_i(instr_op_i), .privilege_level_i(privilege_level_i), .exec_ok_o(exec_ok_o),
  .invalid_opcode_fault_o(invalid_opcode_fault_o), .protection_fault_o(protection_fault_o),
  .bounds_nop_o(bounds_nop_o), .extended_feature_mask_o(extended_feature_mask_o)
);

// ---- tb/ssfg_gate_tb.sv ----
`define CHK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("[ERR] %s exp %0h got %0h", nm, exp, got); \
    end \
  end

module ssfg_gate_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // one gate request and what it should give: flags are ok, ud, gp, nop, prefix ignore
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] priv;
    logic [1:0] sel;
    logic [63:0] wdata;
    logic [4:0] flg;
    logic [63:0] mask;
  } ssfg_row_t;
  // one query and its four result words
  typedef struct packed {
    logic [31:0] leaf, sub, eax, ebx, ecx, edx;
  } ssfg_qrow_t;

  int n_errors = 0;
  int checks_done = 0;
  logic clk_sys_i = 1'h0, rstn_i = 1'h0, cr4_wr_i = 1'h0, instr_valid_i = 1'h0;
  logic query_valid_i = 1'h0;
  logic [31:0] cr4_wdata_i = 32'h0, instr_sel_i = 32'h0, query_leaf_i = 32'h0;
  logic [31:0] query_sub_i = 32'h0;
  ssfg_pkg::ssfg_op_t instr_op_i = ssfg_pkg::SSFG_OP_OTHER;
  logic [1:0] privilege_level_i = 2'h0;
  logic [63:0] instr_wdata_i = 64'h0;
  // supervisor map is empty by default, so these stay fixed
  logic [63:0] init_state_i = 64'h6, supv_mask_i = 64'h0;
  logic os_save_enable_o, done_o, exec_ok_o, invalid_opcode_fault_o, protection_fault_o;
  logic bounds_nop_o, bounds_prefix_ignore_o, query_done_o;
  logic [63:0] rd_data_o, extended_feature_mask_o;
  logic [31:0] query_eax_o, query_ebx_o, query_ecx_o, query_edx_o;
  wire logic [4:0] flags_w = {exec_ok_o, invalid_opcode_fault_o, protection_fault_o,
    bounds_nop_o, bounds_prefix_ignore_o};
  wire logic [128:0] qres_w = {query_done_o, query_eax_o, query_ebx_o, query_ecx_o,
    query_edx_o};
  // outputs of the gate built without the feature set
  logic os0_w, ud0_w;
  logic [31:0] ecx0_w;

  // rows run in order, each one sees the mask the previous row left
  ssfg_row_t rows [34] = '{
    '{4'h8, 2'h0, 2'h0, 64'h7, 5'h10, 64'h7}, '{4'h8, 2'h0, 2'h0, 64'h5, 5'h04, 64'h7},
    '{4'h8, 2'h0, 2'h0, 64'h6, 5'h04, 64'h7}, '{4'h8, 2'h0, 2'h0, 64'hf, 5'h04, 64'h7},
    '{4'h8, 2'h0, 2'h0, 64'h17, 5'h04, 64'h7}, '{4'h8, 2'h0, 2'h0, 64'h107, 5'h04, 64'h7},
    '{4'h8, 2'h0, 2'h0, 64'h407, 5'h04, 64'h7},
    '{4'h8, 2'h0, 2'h0, 64'h8000_0000_0000_0007, 5'h04, 64'h7},
    '{4'h8, 2'h0, 2'h0, 64'h27, 5'h04, 64'h7}, '{4'h8, 2'h1, 2'h0, 64'h1f, 5'h04, 64'h7},
    '{4'h8, 2'h0, 2'h1, 64'h1f, 5'h04, 64'h7}, '{4'h7, 2'h3, 2'h0, 64'h0, 5'h10, 64'h7},
    '{4'h9, 2'h0, 2'h0, 64'h0, 5'h10, 64'h7}, '{4'ha, 2'h0, 2'h0, 64'h0, 5'h02, 64'h7},
    '{4'hb, 2'h0, 2'h0, 64'h0, 5'h11, 64'h7}, '{4'h8, 2'h0, 2'h0, 64'h1f, 5'h10, 64'h1f},
    '{4'ha, 2'h0, 2'h0, 64'h0, 5'h10, 64'h1f}, '{4'hb, 2'h0, 2'h0, 64'h0, 5'h10, 64'h1f},
    '{4'h8, 2'h0, 2'h0, 64'h3, 5'h10, 64'h3}, '{4'h9, 2'h0, 2'h0, 64'h0, 5'h08, 64'h3},
    '{4'hc, 2'h0, 2'h0, 64'h0, 5'h10, 64'h3}, '{4'h0, 2'h0, 2'h0, 64'h0, 5'h10, 64'h3},
    '{4'h1, 2'h0, 2'h0, 64'h0, 5'h10, 64'h3}, '{4'h2, 2'h0, 2'h0, 64'h0, 5'h10, 64'h3},
    '{4'h3, 2'h0, 2'h0, 64'h0, 5'h10, 64'h3}, '{4'h4, 2'h0, 2'h0, 64'h0, 5'h10, 64'h3},
    '{4'h5, 2'h0, 2'h0, 64'h0, 5'h08, 64'h3}, '{4'h6, 2'h0, 2'h0, 64'h0, 5'h08, 64'h3},
    '{4'hd, 2'h0, 2'h0, 64'h0, 5'h04, 64'h3}, '{4'he, 2'h0, 2'h0, 64'h0, 5'h04, 64'h3},
    '{4'h7, 2'h0, 2'h2, 64'h0, 5'h04, 64'h3}, '{4'h7, 2'h0, 2'h1, 64'h0, 5'h10, 64'h3},
    '{4'hf, 2'h0, 2'h0, 64'h0, 5'h10, 64'h3}, '{4'h8, 2'h0, 2'h0, 64'h1f, 5'h10, 64'h1f}
  };
  // first two rows run straight after reset, the rest with mask 0x1f
  ssfg_qrow_t qrows [10] = '{
    '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0400_0000, 32'h0},
    '{32'hd, 32'h0, 32'h1f, 32'h240, 32'h440, 32'h0},
    '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0c00_0000, 32'h0},
    '{32'hd, 32'h0, 32'h1f, 32'h440, 32'h440, 32'h0},
    '{32'hd, 32'h1, 32'h7, 32'h3c0, 32'h0, 32'h0},
    '{32'hd, 32'h2, 32'h100, 32'h240, 32'h0, 32'h0},
    '{32'hd, 32'h3, 32'h40, 32'h3c0, 32'h0, 32'h0},
    '{32'hd, 32'h4, 32'h40, 32'h400, 32'h0, 32'h0},
    '{32'hd, 32'h5, 32'h0, 32'h0, 32'h0, 32'h0},
    '{32'hd, 32'h3f, 32'h0, 32'h0, 32'h0, 32'h0}
  };

  ssfg_gate dut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cr4_wr_i(cr4_wr_i), .cr4_wdata_i(cr4_wdata_i),
    .os_save_enable_o(os_save_enable_o), .instr_valid_i(instr_valid_i),
    .instr_op_i(instr_op_i), .privilege_level_i(privilege_level_i),
    .instr_sel_i(instr_sel_i), .instr_wdata_i(instr_wdata_i), .init_state_i(init_state_i),
    .supv_mask_i(supv_mask_i), .done_o(done_o), .exec_ok_o(exec_ok_o),
    .invalid_opcode_fault_o(invalid_opcode_fault_o), .protection_fault_o(protection_fault_o),
    .bounds_nop_o(bounds_nop_o), .bounds_prefix_ignore_o(bounds_prefix_ignore_o),
    .rd_data_o(rd_data_o), .extended_feature_mask_o(extended_feature_mask_o),
    .query_valid_i(query_valid_i), .query_leaf_i(query_leaf_i), .query_sub_i(query_sub_i),
    .query_done_o(query_done_o), .query_eax_o(query_eax_o), .query_ebx_o(query_ebx_o),
    .query_ecx_o(query_ecx_o), .query_edx_o(query_edx_o)
  );

  // same stimulus into a gate without the feature set
  ssfg_gate #(.SUPPORT(1'b0)) dut_off (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cr4_wr_i(cr4_wr_i), .cr4_wdata_i(cr4_wdata_i),
    .os_save_enable_o(os0_w), .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i),
    .privilege_level_i(privilege_level_i), .instr_sel_i(instr_sel_i),
    .instr_wdata_i(instr_wdata_i), .init_state_i(init_state_i), .supv_mask_i(supv_mask_i),
    .done_o(), .exec_ok_o(), .invalid_opcode_fault_o(ud0_w), .protection_fault_o(),
    .bounds_nop_o(), .bounds_prefix_ignore_o(), .rd_data_o(), .extended_feature_mask_o(),
    .query_valid_i(query_valid_i), .query_leaf_i(query_leaf_i), .query_sub_i(query_sub_i),
    .query_done_o(), .query_eax_o(), .query_ebx_o(), .query_ecx_o(ecx0_w), .query_edx_o()
  );

  // free-running 50 MHz clock
  initial
  begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // verdict; the only place the run ends
  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // one gate request; the answer lands on the same edge that takes it
  task automatic do_op(input logic [3:0] op, input logic [1:0] pv, input logic [1:0] sl,
    input logic [63:0] wd);
    @(posedge clk_sys_i);
    instr_valid_i <= 1'h1;
    instr_op_i <= ssfg_pkg::ssfg_op_t'(op);
    privilege_level_i <= pv;
    instr_sel_i <= {30'h0, sl};
    instr_wdata_i <= wd;
    @(posedge clk_sys_i);
    instr_valid_i <= 1'h0;
    #1;
    `CHK("done", 1'h1, done_o)
  endtask : do_op

  // control_reg_four write; a clear sets every other bit to show they are ignored
  task automatic set_os(input logic en);
    @(posedge clk_sys_i);
    cr4_wr_i <= 1'h1;
    cr4_wdata_i <= en ? 32'h0004_0000 : 32'hfffb_ffff;
    @(posedge clk_sys_i);
    cr4_wr_i <= 1'h0;
    #1;
    `CHK("os_enable", en, os_save_enable_o)
  endtask : set_os

  // query rows lo..hi, all four words and done compared at once
  task automatic run_q(input int lo, input int hi);
    for (int i = lo; i <= hi; i++)
    begin
      @(posedge clk_sys_i);
      query_valid_i <= 1'h1;
      query_leaf_i <= qrows[i].leaf;
      query_sub_i <= qrows[i].sub;
      @(posedge clk_sys_i);
      query_valid_i <= 1'h0;
      #1;
      `CHK("query", {1'h1, qrows[i][127:0]}, qres_w)
    end
  endtask : run_q

  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'h1;
    @(posedge clk_sys_i);
    #1;
    `CHK("reset_mask", {1'h0, 64'h1}, {os_save_enable_o, extended_feature_mask_o})
    `CHK("reset_out", {64'h0, 5'h0, 129'h0}, {rd_data_o, flags_w, qres_w})
    run_q(0, 1);
    set_os(1'h1);
    // without the feature set the enable never sticks and detail reads zero
    `CHK("off_os", 1'h0, os0_w)
    `CHK("off_query", 32'h0, ecx0_w)
    foreach (rows[i])
    begin
      do_op(rows[i].op, rows[i].priv, rows[i].sel, rows[i].wdata);
      `CHK("flags", rows[i].flg, flags_w)
      `CHK("mask", rows[i].mask, extended_feature_mask_o)
      `CHK("off_ud", rows[i].op <= 4'h9, ud0_w)
    end
    // last good read was selector 1: mask 0x3 under init flags 0x6
    `CHK("rd_data", 64'h2, rd_data_o)
    run_q(2, 9);
    // os enable off: family faults, bounds fall back even with 4:3 set
    set_os(1'h0);
    for (int k = 0; k < 13; k++)
    begin
      do_op(k[3:0], 2'h0, 2'h0, 64'h7);
      `CHK("os_off", (k<10)?5'h08:(k==10)?5'h02:(k==11)?5'h11:5'h10, flags_w)
    end
    `CHK("os_off_keep", {64'h1f, 64'h2}, {extended_feature_mask_o, rd_data_o})
    // second reset in mid-run
    @(posedge clk_sys_i);
    rstn_i <= 1'h0;
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'h1;
    @(posedge clk_sys_i);
    #1;
    `CHK("rereset", {1'h0, 64'h1}, {os_save_enable_o, extended_feature_mask_o})
    complete_run();
  end
endmodule : ssfg_gate_tb
